// [rtl/flash_identify_map.svh]
// Offsets, codes and counts of the identify read-out path.
// Assumes inclusion by bare name from the package, the design file and the bench.
`ifndef FLASH_IDENTIFY_MAP_SVH
`define FLASH_IDENTIFY_MAP_SVH

// First identify opcode
`define ID_OPCODE_A   8'h90
// Second identify opcode
`define ID_OPCODE_B   8'hab
// Address of the maker byte
`define ADDR_MANUF    24'h000000
// Address of the device byte
`define ADDR_DEVICE   24'h000001
// Header length: opcode plus address
`define HDR_BITS      6'd32
// Index of the last header bit
`define HDR_LAST      6'd31
// Last bit index within an output byte
`define BYTE_LAST     3'd7
// Opcode field inside the header word
`define HDR_OP_MSB    31
`define HDR_OP_LSB    24
// Log buffer depth in records
`define LOG_DEPTH     8

`endif

// [rtl/flash_identify_pkg.sv]
// Types shared by the identify read-out path.
// Assumes the map header sits beside it.
`include "flash_identify_map.svh"

package flash_identify_pkg;

	// ****************************************
	// Transaction record
	// ****************************************

	// One decoded identify header as seen by the core side
	typedef struct packed {
		logic [7:0]  opcode;   // Received opcode
		logic [23:0] address;  // Received start address
		logic        accepted; // Read-out was entered
	} id_record_type;

	// Width of one record in the log buffer
	localparam int RecordWidth = $bits(id_record_type);

endpackage : flash_identify_pkg

// [rtl/flash_identify_readout.sv]
// Identify read-out path of a serial flash: serial link, decode, log buffer.
// Assumes the serial clock comes from the host and stands still outside frames,
// and that the busy input comes from a flip-flop in the core clock domain.
`timescale 1ns/1ps
`include "flash_identify_map.svh"

// ****************************************
// Log buffer
// ****************************************

// Synchronous FIFO with valid and ready on both sides
module flash_identify_fifo #(
	parameter int Width = 8,
	parameter int Depth = 8
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [Width-1:0] inData,
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [Width-1:0] outData
);
	localparam int PtrWidth = $clog2(Depth);

	logic [Width-1:0]  store [Depth];  // Entry storage
	logic [PtrWidth:0] wrPtr_reg;      // Write pointer with wrap bit
	logic [PtrWidth:0] rdPtr_reg;      // Read pointer with wrap bit
	logic              pushing;        // Entry taken this cycle
	logic              popping;        // Entry leaves this cycle

	// Full when pointers differ only in the wrap bit
	assign inReady  = !((wrPtr_reg[PtrWidth] != rdPtr_reg[PtrWidth]) &&
		(wrPtr_reg[PtrWidth-1:0] == rdPtr_reg[PtrWidth-1:0]));
	assign outValid = (wrPtr_reg != rdPtr_reg);
	assign outData  = store[rdPtr_reg[PtrWidth-1:0]];
	assign pushing  = inValid && inReady;
	assign popping  = outValid && outReady;

	// Storage write, no reset needed on data
	always_ff @(posedge clock) begin
		if (pushing) begin
			store[wrPtr_reg[PtrWidth-1:0]] <= inData;
		end
	end

	// Pointer advance
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wrPtr_reg <= '0;
			rdPtr_reg <= '0;
		end else begin
			if (pushing) begin
				wrPtr_reg <= wrPtr_reg + 1'b1;
			end
			if (popping) begin
				rdPtr_reg <= rdPtr_reg + 1'b1;
			end
		end
	end
endmodule : flash_identify_fifo

// ****************************************
// Top: serial link and core side
// ****************************************

module flash_identify_readout #(
	parameter logic [7:0] ManufId  = 8'h5a, // Arbitrary neutral value
	parameter logic [7:0] DeviceId = 8'ha5  // Arbitrary neutral value
) (
	input  wire logic                                clock,
	input  wire logic                                rst,
	input  wire logic                                sck,
	input  wire logic                                csN,
	input  wire logic                                si,
	output logic                                     soOut,
	output logic                                     soOe,
	input  wire logic                                busy,
	output logic                                     logValid,
	input  wire logic                                logReady,
	output flash_identify_pkg::id_record_type        logData,
	output logic                                     logOverflow
);

	// ****************************************
	// Link domain, clocked by sck, cleared by select high
	// ****************************************

	logic [5:0]  bitCnt_reg;    // Header bits taken, saturates
	logic [31:0] shiftIn_reg;   // Opcode and address
	logic [31:0] shiftIn_next;  // Header with current bit added
	logic        idMode_reg;    // Read-out active
	logic        firstSel_reg;  // Start with device byte
	logic        hdrValid_reg;  // Header complete, level to core
	logic        busySyncA_reg; // Busy synchroniser, first stage
	logic        busySyncB_reg; // Busy synchroniser, second stage
	logic [2:0]  outCnt_reg;    // Bit within output byte
	logic        selFlip_reg;   // Flips after each byte
	logic        soOut_reg;     // Output bit
	logic        soOe_reg;      // Output drive
	logic        opcodeHit;     // Opcode is one of the two
	logic [7:0]  curByte;       // Byte now going out

	assign shiftIn_next = {shiftIn_reg[30:0], si};
	assign opcodeHit = (shiftIn_next[`HDR_OP_MSB:`HDR_OP_LSB] == `ID_OPCODE_A) ||
		(shiftIn_next[`HDR_OP_MSB:`HDR_OP_LSB] == `ID_OPCODE_B);
	// Only address bit zero picks the byte; higher bits are ignored
	assign curByte = (firstSel_reg ^ selFlip_reg) ? DeviceId : ManufId;

	// Busy crosses as a level; 32 header edges give it time to settle
	always_ff @(posedge sck or posedge csN) begin
		if (csN) begin
			busySyncA_reg <= 1'b0;
			busySyncB_reg <= 1'b0;
		end else begin
			busySyncA_reg <= busy;
			busySyncB_reg <= busySyncA_reg;
		end
	end

	// Header shift on rising edges, MSB first
	always_ff @(posedge sck or posedge csN) begin
		if (csN) begin
			bitCnt_reg  <= 6'd0;
			shiftIn_reg <= 32'h0000_0000;
		end else if (bitCnt_reg != `HDR_BITS) begin
			bitCnt_reg  <= bitCnt_reg + 6'd1;
			shiftIn_reg <= shiftIn_next;
		end
	end

	// Decode at the last address bit
	always_ff @(posedge sck or posedge csN) begin
		if (csN) begin
			idMode_reg   <= 1'b0;
			firstSel_reg <= 1'b0;
			hdrValid_reg <= 1'b0;
		end else if (bitCnt_reg == `HDR_LAST) begin
			// Busy blocks decoding, the ongoing cycle is untouched
			idMode_reg   <= opcodeHit && !busySyncB_reg;
			firstSel_reg <= si;
			hdrValid_reg <= 1'b1;
		end
	end

	// Output shift on falling edges
	always_ff @(negedge sck or posedge csN) begin
		if (csN) begin
			outCnt_reg  <= 3'd0;
			selFlip_reg <= 1'b0;
			soOut_reg   <= 1'b0;
			soOe_reg    <= 1'b0;
		end else if (idMode_reg) begin
			soOut_reg  <= curByte[3'd7 - outCnt_reg];
			soOe_reg   <= 1'b1;
			outCnt_reg <= outCnt_reg + 3'd1;
			if (outCnt_reg == `BYTE_LAST) begin
				selFlip_reg <= !selFlip_reg;
			end
		end
	end

	assign soOut = soOut_reg;
	assign soOe  = soOe_reg;

	// ****************************************
	// Core domain: record capture and log
	// ****************************************

	logic hdrSyncA_reg;  // Header level, first stage
	logic hdrSyncB_reg;  // Header level, second stage
	logic hdrSyncC_reg;  // Delayed copy for edge detect
	logic pending_reg;   // Record waiting for buffer room
	logic overflow_reg;  // A record was lost, sticky
	logic fifoInReady;   // Buffer has room
	logic fifoOutValid;  // Buffer holds a record
	logic fifoPop;       // Record moves to output stage
	logic hdrRise;       // New header seen
	logic logValid_reg;  // Output stage full
	flash_identify_pkg::id_record_type pendRec_reg; // Waiting record
	flash_identify_pkg::id_record_type fifoOut;     // Buffer head
	flash_identify_pkg::id_record_type logData_reg; // Output stage

	assign hdrRise = hdrSyncB_reg && !hdrSyncC_reg;
	assign fifoPop = fifoOutValid && (!logValid_reg || logReady);

	// Header level synchroniser
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			hdrSyncA_reg <= 1'b0;
			hdrSyncB_reg <= 1'b0;
			hdrSyncC_reg <= 1'b0;
		end else begin
			hdrSyncA_reg <= hdrValid_reg;
			hdrSyncB_reg <= hdrSyncA_reg;
			hdrSyncC_reg <= hdrSyncB_reg;
		end
	end

	// Capture; header is frozen while the level is high
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pending_reg  <= 1'b0;
			pendRec_reg  <= '0;
			overflow_reg <= 1'b0;
		end else begin
			if (hdrRise) begin
				// New record wins over the push that empties the slot
				pending_reg          <= 1'b1;
				pendRec_reg.opcode   <= shiftIn_reg[31:24];
				pendRec_reg.address  <= shiftIn_reg[23:0];
				pendRec_reg.accepted <= idMode_reg;
				if (pending_reg && !fifoInReady) begin
					overflow_reg <= 1'b1;
				end
			end else if (pending_reg && fifoInReady) begin
				pending_reg <= 1'b0;
			end
		end
	end

	flash_identify_fifo #(
		.Width (flash_identify_pkg::RecordWidth),
		.Depth (`LOG_DEPTH)
	) logFifo (
		.clock    (clock),
		.rst      (rst),
		.inValid  (pending_reg),
		.inReady  (fifoInReady),
		.inData   (pendRec_reg),
		.outValid (fifoOutValid),
		.outReady (fifoPop),
		.outData  (fifoOut)
	);

	// Registered output stage so outputs come from flops
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			logValid_reg <= 1'b0;
			logData_reg  <= '0;
		end else if (!logValid_reg || logReady) begin
			logValid_reg <= fifoOutValid;
			if (fifoOutValid) begin
				logData_reg <= fifoOut;
			end
		end
	end

	assign logValid    = logValid_reg;
	assign logData     = logData_reg;
	assign logOverflow = overflow_reg;

	// ****************************************
	// Checks
	// ****************************************

	sequence seqHeaderEnd;
		(bitCnt_reg == `HDR_LAST) && opcodeHit && !busySyncB_reg;
	endsequence

	a_id_mode_entry: assert property (@(posedge sck) disable iff (csN)
		seqHeaderEnd |=> idMode_reg && (bitCnt_reg == `HDR_BITS))
		else $error("identify opcode did not enter read-out");

	a_first_byte_sel: assert property (@(negedge sck) disable iff (csN)
		idMode_reg && (outCnt_reg == 3'd0) && !selFlip_reg |=>
		soOut_reg == (firstSel_reg ? DeviceId[7] : ManufId[7]))
		else $error("first output byte does not follow address");

	a_bytes_alternate: assert property (@(negedge sck) disable iff (csN)
		idMode_reg && (outCnt_reg == `BYTE_LAST) |=>
		(selFlip_reg != $past(selFlip_reg)) && (outCnt_reg == 3'd0))
		else $error("output bytes did not alternate");

	a_select_ends: assert property (@(posedge clock) disable iff (rst)
		csN |-> !soOe_reg && !idMode_reg)
		else $error("output still driven with select high");

	a_busy_ignored: assert property (@(posedge sck) disable iff (csN)
		(bitCnt_reg == `HDR_LAST) && busySyncB_reg |=> !idMode_reg [*2])
		else $error("identify decoded while busy");

	a_rising_sample: assert property (@(posedge sck) disable iff (csN)
		(bitCnt_reg != `HDR_BITS) |=> shiftIn_reg[0] == $past(si))
		else $error("header bit not sampled on rising edge");

	a_log_stable: assert property (@(posedge clock) disable iff (rst)
		logValid_reg && !logReady |=> logValid_reg && $stable(logData_reg))
		else $error("log output changed while stalled");

endmodule : flash_identify_readout

// [dv/spi_host_model.sv]
// Host side model: an SPI controller that issues identify frames in mode 0.
// Assumes the bench calls its frame task; serial clock stands still between frames.
`timescale 1ns/1ps

module spi_host_model (
	output logic      sck,
	output logic      csN,
	output logic      si,
	input  wire logic soOut,
	input  wire logic soOe
);

	// ****************************************
	// Idle levels
	// ****************************************

	// Mode 0: clock idles low, select high
	// Select rises just after time zero, so the link logic, which has no
	// other reset, always sees a clearing edge before the first frame
	initial begin
		sck = 1'b0;
		csN = 1'b0;
		si  = 1'b0;
		#1 csN = 1'b1;
	end

	// ****************************************
	// Frame task
	// ****************************************

	// Header MSB first, then nBits read back on rising edges
	task automatic frame(input logic [7:0] op, input logic [23:0] ad, input int nBits,
			output logic [31:0] rx, output logic oeAll, output logic oeAny);
		logic [31:0] hdr;
		hdr   = {op, ad}; // Opcode then address
		rx    = '0;
		oeAll = 1'b1;
		oeAny = 1'b0;
		csN   = 1'b0;
		#21;
		for (int i = 0; i < 32 + nBits; i++) begin
			// Past the header the line toggles, the device must ignore it
			si = (i < 32) ? hdr[31-i] : ~si;
			#24 sck = 1'b1; // Data in and out both taken here
			oeAny = oeAny | soOe;
			if (i >= 32) begin
				rx    = {rx[30:0], soOut};
				oeAll = oeAll & soOe;
			end
			#24 sck = 1'b0;
		end
		#20 csN = 1'b1; // Only way to leave read-out
		si = ~si; // Released line shows no stale value
		#100;
	endtask : frame

endmodule : spi_host_model

// [dv/tb_flash_identify_readout.sv]
// Self-checking bench of the identify read-out path with a host model.
// Assumes the design files and the map header are compiled first.
`timescale 1ns/1ps
`include "flash_identify_map.svh"

module tb_flash_identify_readout;

	// ****************************************
	// Signals and expectations
	// ****************************************

	localparam logic [7:0] ManufVal = 8'h3c; // Arbitrary value
	localparam logic [7:0] DevVal   = 8'hc3; // Arbitrary value
	logic clock, rst, sck, csN, si, soOut, soOe, busy;
	logic logValid, logReady, logOverflow;
	logic ofl; // Next record overwrites the pending one
	logic [1:0] readyMode; // 0 stall, 1 random, 2 always ready
	flash_identify_pkg::id_record_type logData;
	flash_identify_pkg::id_record_type expQ[$]; // Records still expected
	logic [7:0]  ops [4] = '{`ID_OPCODE_A, `ID_OPCODE_B, 8'h9f, 8'h03};
	logic [23:0] ads [4] = '{`ADDR_MANUF, `ADDR_DEVICE, 24'hfffffe, 24'hffffff};
	int errorCnt, numChecks, seed, seedReady, rnd, rndReady;

	flash_identify_readout #(.ManufId(ManufVal), .DeviceId(DevVal)) u_flash_identify_readout (
		.clock(clock), .rst(rst), .sck(sck), .csN(csN), .si(si), .soOut(soOut),
		.soOe(soOe), .busy(busy), .logValid(logValid), .logReady(logReady),
		.logData(logData), .logOverflow(logOverflow));

	spi_host_model u_spi_host_model (
		.sck(sck), .csN(csN), .si(si), .soOut(soOut), .soOe(soOe));

	// 125 MHz core clock
	initial clock = 1'b0;
	always #4 clock = ~clock;

	// ****************************************
	// Helpers
	// ****************************************

	task automatic check(input logic [63:0] got, input logic [63:0] exp);
		numChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// First nBits of the alternating id stream
	function automatic logic [31:0] expStream(input logic first, input int nBits);
		logic [31:0] s;
		for (int b = 0; b < 4; b++) s[31-8*b -: 8] = (b[0] ^ first) ? DevVal : ManufVal;
		return s >> (32 - nBits);
	endfunction : expStream

	// One frame with busy level b; record queued before it can appear
	task automatic runFrame(input logic [7:0] op, input logic [23:0] ad, input logic b,
			input int nBits);
		logic [31:0] rx;
		logic oeAll, oeAny, ok;
		@(negedge clock);
		busy = b;
		repeat (4) @(negedge clock);
		ok = (op == `ID_OPCODE_A || op == `ID_OPCODE_B) && !b;
		if (ofl) void'(expQ.pop_back());
		expQ.push_back('{opcode: op, address: ad, accepted: ok});
		u_spi_host_model.frame(op, ad, nBits, rx, oeAll, oeAny);
		if (ok) begin
			check(64'(oeAll), 64'h1);
			check(64'(rx), 64'(expStream(ad[0], nBits)));
		end else begin
			check(64'(oeAny), 64'h0);
		end
		check(64'({soOe, soOut}), 64'h0);
	endtask : runFrame

	// Bounded wait until every queued record was seen
	task automatic drain();
		for (int k = 0; k < 3000 && expQ.size() != 0; k++) @(posedge clock);
		repeat (4) @(negedge clock);
		check(64'(expQ.size()), 64'h0);
		check(64'(logValid), 64'h0);
		// A used-up bound goes straight to the report
		if (expQ.size() != 0) endOfTest();
	endtask : drain

	task automatic endOfTest();
		$display("checks %0d errors %0d", numChecks, errorCnt);
		if (errorCnt == 0 && numChecks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : endOfTest

	// ****************************************
	// Consumer side and record monitor
	// ****************************************

	// Ready changes on the falling edge, separate seed keeps it repeatable
	always @(negedge clock) begin
		rndReady = $random(seedReady);
		logReady <= (readyMode == 2'd2) || (readyMode == 2'd1 && rndReady[0]);
	end

	// A record leaves when valid and ready meet at a rising edge
	always @(posedge clock) begin
		if (rst === 1'b0 && logValid === 1'b1 && logReady === 1'b1) begin
			if (expQ.size() == 0) check(64'h1, 64'h0);
			else check(64'(logData), 64'(expQ.pop_front()));
		end
	end

	// ****************************************
	// Main sequence
	// ****************************************

	initial begin
		seed = 87;
		seedReady = 87;
		errorCnt = 0;
		numChecks = 0;
		rst = 1'b1;
		busy = 1'b0;
		ofl = 1'b0;
		logReady = 1'b0;
		readyMode = 2'd2;
		repeat (16) @(posedge clock);
		@(negedge clock) rst = 1'b0;
		// Every opcode kind against boundary addresses and lengths
		foreach (ops[i]) foreach (ads[j]) runFrame(ops[i], ads[j], 1'b0, 8 * (j + 1));
		runFrame(`ID_OPCODE_B, `ADDR_DEVICE, 1'b1, 16);
		// Random traffic with consumer stalls and odd abort points
		readyMode = 2'd1;
		repeat (40) begin
			rnd = $random(seed);
			runFrame(rnd[2] ? rnd[10:3] : (rnd[1] ? `ID_OPCODE_B : `ID_OPCODE_A),
				rnd[31:8], rnd[5:4] == 2'b00, 8 + ($unsigned($random(seed)) % 25));
		end
		drain();
		// Stalled consumer: one in output stage, eight in buffer, tenth pending,
		// eleventh overwrites the pending one
		readyMode = 2'd0;
		for (int k = 0; k < 11; k++) begin
			ofl = (k == 10);
			runFrame(`ID_OPCODE_A, 24'(k), 1'b0, 8);
		end
		ofl = 1'b0;
		check(64'(logOverflow), 64'h1);
		readyMode = 2'd2;
		drain();
		endOfTest();
	end

	// Hang guard
	initial begin
		// 80,000 core clocks, well above a normal run
		#640000;
		errorCnt++;
		endOfTest();
	end

endmodule : tb_flash_identify_readout
